//--- hw/eewc_pkg.sv
// constants and types for the data eeprom write control block
// assumes one 200 MHz clock and a byte-wide cpu memory port
// Function
// - 32 byte data array, separate memory
// - cpu uses plain byte reads and writes
// - detect write end, raise done request
// - reset loads control register with 08H
// - control register at FFD8H, bit or byte
// - bit7 0, sel 6:4, bit3 1, 2 1 0
// - codes 0 to 5 pick clock/8 to /256
// - code 6 picks timer output; 7 forbidden
// - enable bits set standby, read, read/write
// - flag 0: idle, write needs write enable
// - flag 1: busy, no access, not writable
// - array writes while busy are ignored
// - clearing read enable clears write enable
`default_nettype none
package eewc_pkg;
    localparam logic [15:0] EEWC_CTRL_ADDR    = 16'hFFD8;
    localparam logic [15:0] EEWC_ARRAY_BASE   = 16'hFE00;
    localparam int          EEWC_DEPTH        = 32;
    localparam logic [7:0]  EEWC_CTRL_RESET   = 8'h08;
    localparam int          EEWC_BIT_FIX0     = 7;
    localparam int          EEWC_SEL_LSB      = 4;
    localparam int          EEWC_BIT_FIX1     = 3;
    localparam int          EEWC_BIT_RDEN     = 2;
    localparam int          EEWC_BIT_BUSY     = 1;
    localparam int          EEWC_BIT_WREN     = 0;
    localparam logic [2:0]  EEWC_SEL_TIMER    = 3'h6;
    localparam int          EEWC_WRITE_TICKS  = 145;
    typedef enum logic [1:0] {
        EEWC_IDLE = 2'b01,
        EEWC_BUSY = 2'b10
    } eewc_state_t;
endpackage
`default_nettype wire

//--- hw/eewc_tick_if.sv
// interface carrying count-clock ticks to the write timer
// assumes both ends share one clock
`timescale 1ns/1ps
`default_nettype none
interface eewc_tick_if;
    logic       tick;
    logic [2:0] sel;
    modport gen (input sel, output tick);
    modport use_ (output sel, input tick);
endinterface
`default_nettype wire

//--- hw/eewc_tick_gen.sv
// count clock generator: divided system clock or timer output
// assumes the timer output is synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module eewc_tick_gen (
    // clock and reset
    input  wire logic     clk_in,
    input  wire logic     rst_b_in,
    // timer output level
    input  wire logic     timer_out_in,
    // tick link
    eewc_tick_if.gen      tk
);
    import eewc_pkg::*;
    logic [7:0] div_reg;
    logic       tmr_reg;
    logic       sel_tick;
    // free running prescaler
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            div_reg <= 8'h00;
            tmr_reg <= 1'b0;
        end else begin
            div_reg <= div_reg + 8'h01;
            tmr_reg <= timer_out_in;
        end
    end
    // pick one tap; code 7 gives no tick so a write never ends
    always_comb begin
        sel_tick = 1'b0;
        case (tk.sel)
            3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5: begin
                // all lower tap bits ones: one tick per 2^(sel+3)
                sel_tick = &(div_reg | ~(8'hFF >> (3'h5 - tk.sel)));
            end
            EEWC_SEL_TIMER: begin
                sel_tick = timer_out_in & ~tmr_reg;
            end
            default: begin
                sel_tick = 1'b0;
            end
        endcase
    end
    assign tk.tick = sel_tick;
endmodule
`default_nettype wire

//--- hw/eewc_top.sv
// data eeprom array with its write control register
// assumes cpu strobes are one-cycle pulses synchronous to clk_in
`timescale 1ns/1ps
`default_nettype none
module eewc_top #(
    parameter int DEPTH = eewc_pkg::EEWC_DEPTH,
    parameter int TICKS = eewc_pkg::EEWC_WRITE_TICKS
) (
    // clock and reset
    input  wire logic        clk_in,
    input  wire logic        rst_b_in,
    // cpu memory port
    input  wire logic [15:0] addr_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    input  wire logic [7:0]  wdata_in,
    output logic      [7:0]  rdata_out,
    // timer output used as count clock
    input  wire logic        second_timer_counter_in,
    // write done request
    output logic             write_done_irq_out
);
    import eewc_pkg::*;
    localparam int AW = $clog2(DEPTH);
    eewc_tick_if tk ();
    logic [7:0]  mem [DEPTH];
    logic [2:0]  count_clock_select_reg;
    logic        array_read_enable_reg;
    logic        array_write_enable_reg;
    eewc_state_t state_reg;
    logic [7:0]  ticks_reg;
    logic [AW-1:0] waddr_reg;
    logic [7:0]  wbyte_reg;
    logic        irq_reg;
    logic [7:0]  rdata_reg;
    logic        ctrl_hit;
    logic        arr_hit;
    logic        busy;
    logic        wr_start;
    logic        wr_end;
    logic [7:0]  ctrl_view;
    logic [AW-1:0] aidx;

    eewc_tick_gen u_tick (
        .clk_in       (clk_in),
        .rst_b_in     (rst_b_in),
        .timer_out_in (second_timer_counter_in),
        .tk           (tk)
    );
    assign tk.sel = count_clock_select_reg;

    // address decode; bit writes arrive as read-modify-write bytes
    assign ctrl_hit = (addr_in == EEWC_CTRL_ADDR);
    assign arr_hit  = (addr_in >= EEWC_ARRAY_BASE) &&
                      (addr_in < EEWC_ARRAY_BASE + 16'(DEPTH));
    assign aidx     = addr_in[AW-1:0];
    assign busy     = (state_reg == EEWC_BUSY);
    // accepted only idle with both enables set
    assign wr_start = wr_in && arr_hit && !busy &&
                      array_read_enable_reg &&
                      array_write_enable_reg;
    assign wr_end   = busy && tk.tick && (ticks_reg == 8'(TICKS - 1));
    // fixed bits are constants, not storage
    assign ctrl_view = {1'b0, count_clock_select_reg, 1'b1,
                        array_read_enable_reg, busy,
                        array_write_enable_reg};

    // control register; busy bit is not writable
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            count_clock_select_reg <= EEWC_CTRL_RESET[6:4];
            array_read_enable_reg  <= EEWC_CTRL_RESET[EEWC_BIT_RDEN];
            array_write_enable_reg <= EEWC_CTRL_RESET[EEWC_BIT_WREN];
        end else if (wr_in && ctrl_hit) begin
            count_clock_select_reg <= wdata_in[6:4];
            array_read_enable_reg  <= wdata_in[EEWC_BIT_RDEN];
            // write enable only follows read enable
            array_write_enable_reg <= wdata_in[EEWC_BIT_WREN] &
                                      wdata_in[EEWC_BIT_RDEN];
        end
    end

    // write sequencer: TICKS count clocks per byte
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            state_reg <= EEWC_IDLE;
            ticks_reg <= 8'h00;
            waddr_reg <= '0;
            wbyte_reg <= 8'h00;
        end else begin
            case (state_reg)
                EEWC_IDLE: begin
                    if (wr_start) begin
                        state_reg <= EEWC_BUSY;
                        ticks_reg <= 8'h00;
                        waddr_reg <= aidx;
                        wbyte_reg <= wdata_in;
                    end
                end
                EEWC_BUSY: begin
                    if (wr_end) begin
                        state_reg <= EEWC_IDLE;
                    end else if (tk.tick) begin
                        ticks_reg <= ticks_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= EEWC_IDLE;
                end
            endcase
        end
    end

    // cell commits when the timed write ends
    always_ff @(posedge clk_in) begin
        if (wr_end) begin
            mem[waddr_reg] <= wbyte_reg;
        end
    end

    // one-cycle done pulse
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= wr_end;
        end
    end
    assign write_done_irq_out = irq_reg;

    // read data; array blocked in standby and while busy
    always_ff @(posedge clk_in) begin
        if (!rst_b_in) begin
            rdata_reg <= 8'h00;
        end else if (rd_in) begin
            if (ctrl_hit) begin
                rdata_reg <= ctrl_view;
            end else if (arr_hit && array_read_enable_reg && !busy) begin
                rdata_reg <= mem[aidx];
            end else begin
                rdata_reg <= 8'h00;
            end
        end
    end
    assign rdata_out = rdata_reg;

    // control register invariants
    a_write_enable_dep: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        array_write_enable_reg |-> array_read_enable_reg)
        else $error("write enable set without read enable");
    a_fixed_bits: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        !ctrl_view[EEWC_BIT_FIX0] && ctrl_view[EEWC_BIT_FIX1])
        else $error("fixed control bits wrong");
    a_reset_value: assert property (@(posedge clk_in)
        !rst_b_in |=> ctrl_view == EEWC_CTRL_RESET)
        else $error("control reset value wrong");
    // busy only moves by the sequencer, never by a register write
    a_flag_readonly: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (wr_in && ctrl_hit && !wr_end) |=> $stable(busy))
        else $error("busy flag changed by a control write");

    // write acceptance and refusal
    a_start_busy: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        wr_start |=> ctrl_view[EEWC_BIT_BUSY])
        else $error("busy not set after accepted write");
    a_ignore_busy: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (busy && wr_in && arr_hit && !wr_end) |=>
        ($stable(wbyte_reg) && $stable(waddr_reg)))
        else $error("write accepted while busy");
    a_no_enable: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (wr_in && arr_hit && !array_write_enable_reg) |-> !wr_start)
        else $error("write taken without write enable");

    // timed write progress, one step per count clock tick
    a_ticks_range: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        busy |-> (ticks_reg < 8'(TICKS)))
        else $error("write tick count out of range");
    a_tick_advance: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (busy && tk.tick && !wr_end) |=>
        (ticks_reg == $past(ticks_reg) + 8'h01))
        else $error("write tick not counted");
    a_tick_hold: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (busy && !tk.tick) |=> $stable(ticks_reg))
        else $error("write tick counted without count clock");

    // done request
    a_irq_pulse: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        write_done_irq_out |=> !write_done_irq_out)
        else $error("done request longer than one cycle");
    a_irq_idle: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        $fell(busy) |-> write_done_irq_out)
        else $error("write ended without done request");
    a_done_idle: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        write_done_irq_out |-> !busy)
        else $error("done request while still busy");

    // array reads blocked while busy and in standby
    a_busy_read: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (rd_in && arr_hit && busy) |=> rdata_out == 8'h00)
        else $error("array read while busy");
    a_standby_read: assert property (@(posedge clk_in)
        disable iff (!rst_b_in)
        (rd_in && arr_hit && !array_read_enable_reg) |=> rdata_out == 8'h00)
        else $error("array read in standby");

    // main scenarios
    c_write: cover property (@(posedge clk_in) wr_start);
    c_done: cover property (@(posedge clk_in) write_done_irq_out);
    c_busy_write: cover property (@(posedge clk_in) busy && wr_in && arr_hit);
    c_ctrl_read: cover property (@(posedge clk_in) rd_in && ctrl_hit);
    c_timer_write: cover property (@(posedge clk_in)
        wr_start && (count_clock_select_reg == EEWC_SEL_TIMER));
endmodule
`default_nettype wire

//--- tb/eewc_cpu_model.sv
// cpu side model: byte reads and writes on the memory port
// assumes the block samples strobes on the rising edge of clk_in
`timescale 1ns/1ps
`default_nettype none
module eewc_cpu_model #(
    parameter int SETTLE = 20 // enable settle wait, shortened for sim
) (
    // clock
    input  wire logic        clk_in,
    // memory port
    output logic      [15:0] addr_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic      [7:0]  wdata_out,
    input  wire logic [7:0]  rdata_in
);
    import eewc_pkg::*;
    // port idle from time zero
    initial begin
        addr_out = 16'h0000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end
    // byte write; released lines flip so stale values never match
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
    endtask
    // byte read, data taken one cycle after the strobe edge
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        addr_out = ~a;
        d = rdata_in;
    endtask
    // read enable first, then write enable, then settle; never code 7
    task automatic enable(input logic [2:0] sel);
        wr(EEWC_CTRL_ADDR, {1'b0, sel, 4'hC});
        wr(EEWC_CTRL_ADDR, {1'b0, sel, 4'hD});
        repeat (SETTLE) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

//--- tb/test_data_eeprom_write_control.sv
// self-checking bench for the data eeprom write control block
// assumes eewc_pkg, eewc_top and the cpu model are compiled first
`timescale 1ns/1ps
`default_nettype none
module test_data_eeprom_write_control;
    import eewc_pkg::*;
    // short write so codes 0 to 6 fit the run; long enough that the
    // timer code stays busy through the checks made during the write
    localparam int TK = 4;
    logic        clk_in = 1'b0;
    logic        rst_b_in;
    logic        tmr = 1'b0;
    logic        wr, rd, irq;
    logic [15:0] addr, ea;
    logic [7:0]  wdata, rdata, got, v;
    logic [15:0] lfsr = 16'h282A;
    // read enable first, then write enable, then a bit clear of read enable
    logic [7:0]  pat [3] = '{8'h86, 8'hA7, 8'h29};
    int          err_count = 0;
    int          n_compared = 0;
    int          k, t;
    always #2.5 clk_in = ~clk_in;
    // timer output level, rising every second clock
    always @(posedge clk_in) begin
        #1;
        tmr = ~tmr;
    end
    eewc_top #(.DEPTH(EEWC_DEPTH), .TICKS(TK)) i_eewc_top (
        .clk_in(clk_in), .rst_b_in(rst_b_in), .addr_in(addr),
        .wr_in(wr), .rd_in(rd), .wdata_in(wdata), .rdata_out(rdata),
        .second_timer_counter_in(tmr), .write_done_irq_out(irq));
    eewc_cpu_model i_eewc_cpu_model (.clk_in(clk_in), .addr_out(addr),
        .wr_out(wr), .rd_out(rd), .wdata_out(wdata), .rdata_in(rdata));
    function automatic logic [15:0] nxt(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // control readback: fixed bits forced, flag untouched, paired enables
    function automatic logic [7:0] ctrl_exp(input logic [7:0] d);
        return {1'b0, d[6:4], 1'b1, d[2], 1'b0, d[2] & d[0]};
    endfunction
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_compared++;
        if (g !== e) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        if (err_count == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    // main sequence
    initial begin
        rst_b_in = 1'b0;
        repeat (10) @(posedge clk_in);
        #1 rst_b_in = 1'b1;
        i_eewc_cpu_model.rd(EEWC_CTRL_ADDR, got);
        chk(got, EEWC_CTRL_RESET);
        for (k = 0; k < 3; k++) begin
            i_eewc_cpu_model.wr(EEWC_CTRL_ADDR, pat[k]);
            i_eewc_cpu_model.rd(EEWC_CTRL_ADDR, got);
            chk(got, ctrl_exp(pat[k]));
        end
        // one timed write per count clock code; a hang ends the loop
        for (k = 0; k < 7; k++) begin
            lfsr = nxt(lfsr);
            ea = EEWC_ARRAY_BASE + {11'h000, lfsr[4:0]};
            v = lfsr[15:8];
            i_eewc_cpu_model.enable(k[2:0]);
            i_eewc_cpu_model.wr(ea, v);
            i_eewc_cpu_model.wr(ea, ~v);
            i_eewc_cpu_model.rd(ea, got);
            chk(got, 8'h00);
            i_eewc_cpu_model.rd(EEWC_CTRL_ADDR, got);
            chk(got, {1'b0, k[2:0], 4'hF});
            t = 0;
            while (irq !== 1'b1 && t < 2000) begin
                @(posedge clk_in);
                #1;
                t++;
            end
            if (irq !== 1'b1) begin
                chk({7'h00, irq}, 8'h01);
                break;
            end
            @(posedge clk_in);
            #1;
            chk({7'h00, irq}, 8'h00);
            i_eewc_cpu_model.rd(EEWC_CTRL_ADDR, got);
            chk(got, {1'b0, k[2:0], 4'hD});
            i_eewc_cpu_model.rd(ea, got);
            chk(got, v);
            i_eewc_cpu_model.wr(EEWC_CTRL_ADDR, {1'b0, k[2:0], 4'hC});
            i_eewc_cpu_model.wr(ea, ~v);
            i_eewc_cpu_model.rd(ea, got);
            chk(got, v);
            i_eewc_cpu_model.wr(EEWC_CTRL_ADDR, 8'h08);
            i_eewc_cpu_model.rd(ea, got);
            chk(got, 8'h00);
        end
        give_verdict();
    end
endmodule
`default_nettype wire
